// ==== sep_command_port.sv ====
/*
  Serial EEPROM command port: FIFO for read prefetch and the command
  decoder, write control and 64 x 16 array.
  Assumes chip select, serial clock and data in are synchronous to mclk
  and the serial clock is far slower than mclk.
*/
`timescale 1ns/100ps

module sep_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  // Pointer width, with one extra wrap bit kept above it
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;

  // Depth must be a power of two for pointer wrap
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("sep_fifo depth must be a power of two");
  end

  // Full when pointers differ only in the wrap bit
  assign in_ready = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data = store[rd_ptr[AW-1:0]];

  // Storage write
  always_ff @(posedge clk) begin
    if (in_valid && in_ready) begin
      store[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  // Write pointer
  always_ff @(posedge clk) begin
    if (reset || flush) begin
      wr_ptr <= '0;
    end else if (in_valid && in_ready) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  // Read pointer
  always_ff @(posedge clk) begin
    if (reset || flush) begin
      rd_ptr <= '0;
    end else if (out_valid && out_ready) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule // sep_fifo

module sep_command_port import sep_pkg::*; #(
  parameter int PROG_CYCLES = PROG_CYCLES_DEF,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Host command lines
  input wire logic chip_select,
  input wire logic serial_clock_in,
  input wire logic serial_data_in,
  // Serial data out with its enable
  output logic serial_data_out,
  output logic serial_data_out_en
);
  // Timer wide enough for the full programming count
  localparam int TW = $clog2(PROG_CYCLES + 1);

  // Timer reload and end detection need two cycles at least
  if (PROG_CYCLES < 2) begin : g_bad_cycles
    $error("sep_command_port needs PROG_CYCLES of at least 2");
  end

  logic clk_in_prev;
  logic clk_in_rise;
  sep_state_t state;
  logic [4:0] bit_cnt;
  logic [7:0] hdr;
  logic [7:0] next_hdr;
  logic [15:0] wdata;
  logic [15:0] next_wdata;
  logic write_enable;
  sep_prog_t armed_op;
  sep_prog_t prog_op;
  logic [ADDR_W-1:0] armed_addr;
  logic [ADDR_W-1:0] prog_addr;
  logic [DATA_W-1:0] armed_data;
  logic [DATA_W-1:0] prog_data;
  logic prog_busy;
  logic [TW-1:0] prog_timer;
  logic prog_start;
  logic prog_end;
  logic status_pending;
  logic start_bit;
  logic hdr_done;
  logic data_done;
  logic read_shift;
  logic [DATA_W-1:0] mem [WORDS];
  logic [ADDR_W-1:0] fetch_addr;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [DATA_W-1:0] fifo_out_data;
  logic [DATA_W-1:0] out_sr;
  logic [3:0] bits_left;

  // Serial clock edge, sampled on every mclk
  always_ff @(posedge mclk) begin
    if (reset) begin
      clk_in_prev <= 1'b0;
    end else begin
      clk_in_prev <= serial_clock_in;
    end
  end

  // Command framing events
  assign clk_in_rise = serial_clock_in & ~clk_in_prev
                       & chip_select; // RULE_03
  assign next_hdr = {hdr[6:0], serial_data_in};
  assign next_wdata = {wdata[14:0], serial_data_in};
  assign start_bit = clk_in_rise && state == ST_IDLE && serial_data_in
                     && !prog_busy; // RULE_02 RULE_18
  assign hdr_done = clk_in_rise && state == ST_HEADER
                    && bit_cnt == LAST_HDR_CNT;
  assign data_done = clk_in_rise && state == ST_DATA
                     && bit_cnt == LAST_DATA_CNT;
  assign read_shift = clk_in_rise && state == ST_READ;
  assign prog_start = !chip_select && armed_op != PROG_NONE; // RULE_15
  assign prog_end = prog_busy && prog_timer == TW'(1);

  // Command sequencer; select low returns it to idle
  always_ff @(posedge mclk) begin
    if (reset || !chip_select) begin // RULE_09
      state <= ST_IDLE;
      bit_cnt <= '0;
    end else if (clk_in_rise) begin
      case (state)
        ST_IDLE: begin
          if (start_bit) begin // RULE_01
            state <= ST_HEADER;
            bit_cnt <= '0;
          end
        end
        ST_HEADER: begin
          bit_cnt <= bit_cnt + 5'h01;
          if (bit_cnt == LAST_HDR_CNT) begin
            case (next_hdr[7:6])
              OP_READ: state <= ST_READ; // RULE_05
              OP_WRITE: state <= ST_DATA; // RULE_13
              OP_EXT: state <= (next_hdr[5:4] == EXT_WRITE_ALL) ?
                               ST_DATA : ST_DONE; // RULE_04
              default: state <= ST_DONE;
            endcase
          end
        end
        ST_DATA: begin
          bit_cnt <= bit_cnt + 5'h01;
          if (bit_cnt == LAST_DATA_CNT) begin
            state <= ST_DONE;
          end
        end
        default: state <= state;
      endcase
    end
  end

  // Opcode and address shifter, then data word shifter
  always_ff @(posedge mclk) begin
    if (reset) begin
      hdr <= '0;
      wdata <= '0;
    end else if (clk_in_rise && state == ST_HEADER) begin
      hdr <= next_hdr;
    end else if (clk_in_rise && state == ST_DATA) begin
      wdata <= next_wdata; // RULE_13
    end
  end

  // Write permission latch
  always_ff @(posedge mclk) begin
    if (reset) begin
      write_enable <= 1'b0; // RULE_10
    end else if (hdr_done && next_hdr[7:6] == OP_EXT) begin
      if (next_hdr[5:4] == EXT_WEN) begin
        write_enable <= 1'b1; // RULE_11
      end else if (next_hdr[5:4] == EXT_WRITE_DISABLE) begin
        write_enable <= 1'b0;
      end
    end
  end

  // Write commands armed until select drops; early drop cancels
  always_ff @(posedge mclk) begin
    if (reset || !chip_select) begin
      armed_op <= PROG_NONE; // RULE_23
    end else if (write_enable && data_done) begin // RULE_12
      armed_op <= (hdr[7:6] == OP_WRITE) ? PROG_WORD : PROG_ALL;
      armed_addr <= hdr[5:0];
      armed_data <= next_wdata;
    end else if (write_enable && hdr_done) begin // RULE_21
      if (next_hdr[7:6] == OP_ERASE) begin
        armed_op <= PROG_ERASE_WORD;
        armed_addr <= next_hdr[5:0];
      end else if (next_hdr[7:6] == OP_EXT
                   && next_hdr[5:4] == EXT_CHIP_ERASE) begin
        armed_op <= PROG_ERASE_ALL;
      end
    end
  end

  // Self-timed programming interval, immune to select
  always_ff @(posedge mclk) begin
    if (reset) begin
      prog_busy <= 1'b0;
      prog_timer <= '0;
      prog_op <= PROG_NONE;
    end else if (prog_start) begin
      prog_busy <= 1'b1;
      prog_timer <= TW'(PROG_CYCLES); // RULE_25
      prog_op <= armed_op;
      prog_addr <= armed_addr;
      prog_data <= armed_data;
    end else if (prog_busy) begin
      prog_timer <= prog_timer - TW'(1); // RULE_23
      if (prog_end) begin
        prog_busy <= 1'b0;
      end
    end
  end

  // Cell array: erase at start, program at end
  always_ff @(posedge mclk) begin
    if (prog_start) begin
      if (armed_op == PROG_WORD || armed_op == PROG_ERASE_WORD) begin
        mem[armed_addr] <= ERASED_WORD; // RULE_14
      end else begin
        for (int i = 0; i < WORDS; i++) begin
          mem[i] <= ERASED_WORD;
        end
      end
    end else if (prog_end && prog_op == PROG_WORD) begin
      mem[prog_addr] <= prog_data; // RULE_13
    end else if (prog_end && prog_op == PROG_ALL) begin
      for (int i = 0; i < WORDS; i++) begin
        mem[i] <= prog_data; // RULE_16
      end
    end
  end

  // Status owed to the host after a started write
  always_ff @(posedge mclk) begin
    if (reset) begin
      status_pending <= 1'b0;
    end else if (prog_start) begin
      status_pending <= 1'b1;
    // Completion while deselected also drops the owed status
    end else if (start_bit
                 || (!chip_select && (!prog_busy || prog_end))) begin
      status_pending <= 1'b0; // RULE_19
    end
  end

  // Read prefetch address, rising through the array
  always_ff @(posedge mclk) begin
    if (reset) begin
      fetch_addr <= '0;
    end else if (hdr_done && next_hdr[7:6] == OP_READ) begin
      fetch_addr <= next_hdr[5:0];
    end else if (fifo_in_valid && fifo_in_ready) begin
      fetch_addr <= fetch_addr + 1'b1; // RULE_07
    end
  end

  // Prefetch fills while a read is selected; one word drains
  // at each word boundary of the outgoing stream
  assign fifo_in_valid = state == ST_READ && chip_select;
  assign fifo_out_ready = read_shift && bits_left == '0;

  sep_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_read_fifo (
    .clk(mclk),
    .reset(reset),
    .flush(!chip_select),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(mem[fetch_addr]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // Read word shifter
  always_ff @(posedge mclk) begin
    if (reset || !chip_select || hdr_done) begin
      out_sr <= '0;
      bits_left <= '0;
    end else if (fifo_out_ready) begin
      out_sr <= {fifo_out_data[14:0], 1'b0}; // RULE_05
      bits_left <= WORD_LAST_BIT;
    end else if (read_shift) begin
      out_sr <= {out_sr[14:0], 1'b0};
      bits_left <= bits_left - 4'h1;
    end
  end

  // Serial data out and its enable
  always_ff @(posedge mclk) begin
    if (reset || !chip_select) begin
      serial_data_out <= 1'b0;
      serial_data_out_en <= 1'b0; // RULE_08
    end else if (hdr_done && next_hdr[7:6] == OP_READ) begin
      serial_data_out <= 1'b0; // RULE_06
      serial_data_out_en <= 1'b1;
    end else if (fifo_out_ready) begin
      serial_data_out <= fifo_out_valid & fifo_out_data[15];
    end else if (read_shift) begin
      serial_data_out <= out_sr[15]; // RULE_07
    end else if (state == ST_IDLE && status_pending) begin
      serial_data_out <= !prog_busy; // RULE_17
      serial_data_out_en <= 1'b1;
    end else if (state != ST_READ) begin
      serial_data_out <= 1'b0;
      serial_data_out_en <= 1'b0;
    end
  end
endmodule // sep_command_port

// ==== sep_command_port_asserts.sv ====
/*
  Pin-level assertions for the serial EEPROM command port.
  Assumes the bind below and a host that parks its lines when deselected.
*/
`timescale 1ns/100ps
module sep_port_chk #(
  parameter int PROG_CYCLES = 60,
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Host lines
  input wire logic chip_select,
  input wire logic serial_clock_in,
  input wire logic serial_data_in,
  // Data out and enable
  input wire logic serial_data_out,
  input wire logic serial_data_out_en
);
  logic sclk_last, cs_q, skr_q1, skr_q2, csr_q1, csr_q2;
  int low_cnt;
  wire skr = chip_select && serial_clock_in && !sclk_last;
  wire csr = chip_select && !cs_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // Edge history of the host lines
  always_ff @(posedge mclk) begin
    sclk_last <= serial_clock_in;
    cs_q <= chip_select;
    {skr_q2, skr_q1} <= {skr_q1, skr};
    {csr_q2, csr_q1} <= {csr_q1, csr};
  end
  // Low output cycles without serial clock
  always_ff @(posedge mclk) begin
    if (reset || !serial_data_out_en || serial_data_out || skr) begin
      low_cnt <= 0;
    end else begin
      low_cnt <= low_cnt + 1;
    end
  end
  sequence en_rise_s;
    $rose(serial_data_out_en);
  endsequence
  sequence en_steady_s;
    serial_data_out_en && $past(serial_data_out_en);
  endsequence
  chk_release_deselect: assert property (
    !chip_select |=> !serial_data_out_en) else $error("driven unselected");
  chk_reset_quiet: assert property (
    $fell(reset) |-> !serial_data_out_en && !serial_data_out)
    else $error("output active after reset");
  chk_rise_low: assert property (
    en_rise_s |-> !serial_data_out) else $error("first bit not low");
  chk_change_cause: assert property (
    en_steady_s ##0 ($changed(serial_data_out) && !skr_q1 && !skr_q2)
    |-> serial_data_out) else $error("output moved without clock");
  chk_en_needs_cs: assert property (
    en_rise_s |-> $past(chip_select)) else $error("enable without select");
  chk_rise_cause: assert property (
    en_rise_s |-> skr_q1 || skr_q2 || csr_q1 || csr_q2)
    else $error("enable rose without cause");
  chk_hold_selected: assert property (
    chip_select && serial_data_out_en && !skr && !skr_q1
    |=> serial_data_out_en) else $error("output dropped while selected");
  chk_busy_bound: assert property (
    low_cnt <= PROG_CYCLES) else $error("busy too long");
endmodule // sep_port_chk

bind sep_command_port sep_port_chk #(.PROG_CYCLES(PROG_CYCLES),
  .FIFO_DEPTH(FIFO_DEPTH)) chk_u (.mclk(mclk), .reset(reset),
  .chip_select(chip_select), .serial_clock_in(serial_clock_in),
  .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
  .serial_data_out_en(serial_data_out_en));

// ==== sep_host_model.sv ====
/*
  Host controller model driving the serial command lines.
  Assumes mclk at 20 MHz; serial clock is nine mclk per period.
  A released data out line reads as the inverse of the driven level.
*/
`timescale 1ns/100ps
module sep_host_model (
  // Clock
  input wire logic mclk,
  // Device outputs
  input wire logic serial_data_out,
  input wire logic serial_data_out_en,
  // Host lines
  output logic chip_select,
  output logic serial_clock_in,
  output logic serial_data_in
);
  // Lines parked low from time zero
  initial begin
    chip_select = 1'b0;
    serial_clock_in = 1'b0;
    serial_data_in = 1'b0;
  end
  // One serial clock period, data out taken before the next rise
  task automatic bit_x(input logic dv, output logic q);
    @(posedge mclk);
    serial_clock_in <= 1'b0;
    serial_data_in <= dv;
    repeat (4) @(posedge mclk);
    serial_clock_in <= 1'b1;
    repeat (4) @(posedge mclk);
    q = serial_data_out_en ? serial_data_out : !serial_data_out;
  endtask
  // Selected, shift n bits MSB first
  task automatic shift(input logic [31:0] v, input int n,
                       output logic [31:0] r);
    logic q;
    r = 32'h0;
    chip_select <= 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      bit_x(v[i], q);
      r = {r[30:0], q};
    end
  endtask
  // Deselect between commands
  task automatic finish_cmd();
    @(posedge mclk);
    chip_select <= 1'b0;
    serial_clock_in <= 1'b0;
    serial_data_in <= 1'b0;
    repeat (10) @(posedge mclk);
  endtask
  // Status poll, data in low, no clocks
  task automatic poll(input int lim, output int busy);
    @(posedge mclk);
    chip_select <= 1'b1;
    repeat (3) @(posedge mclk);
    busy = 0;
    while ((serial_data_out_en !== 1'b1 || serial_data_out !== 1'b1)
           && busy < lim) begin
      @(posedge mclk);
      busy++;
    end
  endtask
endmodule // sep_host_model

// ==== sep_pkg.sv ====
/*
  Constants, opcodes and types for the serial EEPROM command port.
  Assumes a 20 MHz system clock and host lines that are already
  synchronous to it.
*/
// Overview of operation
// [RULE_01] Ignore input until a start bit arrives
// [RULE_02] First one after select rises is start
// [RULE_03] Sample data in on serial clock rise
// [RULE_04] Opcode 00 picks extended command by two bits
// [RULE_05] Read shifts out addressed 16-bit word
// [RULE_06] Dummy zero on last address edge, then data
// [RULE_07] Reads continue at higher addresses while selected
// [RULE_08] Data out released while select is low
// [RULE_09] Select low resets the command logic
// [RULE_10] Reset leaves writes disabled
// [RULE_11] Write enable holds until write disable
// [RULE_12] Writes ignored when disabled; reads still work
// [RULE_13] Write stores 16 data bits at address
// [RULE_14] Word and all writes erase before programming
// [RULE_15] Programming starts when select drops after 25th
// [RULE_16] Write-all programs all 64 words at once
// [RULE_17] Selected during write shows busy low, ready high
// [RULE_18] No command accepted while busy
// [RULE_19] No status driven while select is low
// [RULE_20] Host holds data in low while polling
// [RULE_21] Word erase and chip erase are optional
// [RULE_22] Host should disable writes when finished
// [RULE_23] Started programming completes; earlier select low cancels
// [RULE_24] Host drops select within four clocks of ready
// [RULE_25] Programming interval timed internally, not over maximum
package sep_pkg;

  // Array geometry
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;
  localparam int WORDS = 64;
  localparam int FIFO_DEPTH_DEF = 16;

  // Opcodes and extended selectors
  localparam logic [1:0] OP_EXT = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] EXT_WRITE_DISABLE = 2'h0;
  localparam logic [1:0] EXT_WRITE_ALL = 2'h1;
  localparam logic [1:0] EXT_CHIP_ERASE = 2'h2;
  localparam logic [1:0] EXT_WEN = 2'h3;

  // Bit counter marks after the start bit
  localparam logic [4:0] LAST_HDR_CNT = 5'h07;
  localparam logic [4:0] LAST_DATA_CNT = 5'h17;
  localparam logic [3:0] WORD_LAST_BIT = 4'hF;

  // Content of an erased cell
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;

  // Programming interval
  localparam int CLK_PERIOD_NS = 50;
  localparam int PROG_TIME_MS = 10;
  localparam int PROG_CYCLES_DEF = PROG_TIME_MS * 1000000 / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_IDLE, ST_HEADER, ST_DATA, ST_READ, ST_DONE
  } sep_state_t;

  typedef enum logic [2:0] {
    PROG_NONE, PROG_WORD, PROG_ALL, PROG_ERASE_WORD, PROG_ERASE_ALL
  } sep_prog_t;

endpackage

// ==== serial_eeprom_command_port_tb_top.sv ====
/*
  Self-checking bench for the serial EEPROM command port.
  Assumes the host model and the bound checker are compiled with it.
*/
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  err_total++; $display("unexpected %s: expected %h seen %h", nm, e, g); \
  end end
module serial_eeprom_command_port_tb_top import sep_pkg::*;;
  localparam int PROG = 60;
  logic mclk;
  logic reset;
  wire logic cs, sclk, sdi, dout, den;
  int err_total;
  int n_compared;
  logic [15:0] exp_mem [WORDS];
  logic [5:0] a;
  logic [15:0] d;
  logic [31:0] r;
  int s;

  sep_command_port #(.PROG_CYCLES(PROG)) dut_u (.mclk(mclk),
    .reset(reset), .chip_select(cs), .serial_clock_in(sclk),
    .serial_data_in(sdi), .serial_data_out(dout),
    .serial_data_out_en(den));
  sep_host_model host_u (.mclk(mclk), .serial_data_out(dout),
    .serial_data_out_en(den), .chip_select(cs),
    .serial_clock_in(sclk), .serial_data_in(sdi));

  // Clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  function automatic logic [15:0] exp_word(input int x);
    return exp_mem[x % WORDS];
  endfunction

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic cmd(input logic [1:0] op, input logic [5:0] ad,
                     input logic [15:0] dv, input bit wr, input bit lead);
    logic [31:0] rr;
    host_u.shift({7'h0, 1'b1, op, ad, dv} >> (wr ? 0 : 16),
                 (wr ? 25 : 9) + (lead ? 3 : 0), rr);
    host_u.finish_cmd();
  endtask

  task automatic prog_wait();
    int b;
    host_u.poll(PROG + 20, b);
    `CHK("busy span", 1'b1, b > PROG - 20 && b <= PROG)
    `CHK("ready", 2'b11, {den, dout})
    host_u.finish_cmd();
  endtask

  task automatic rd(input int a0, input int k);
    logic [31:0] rr;
    host_u.shift({23'h0, 1'b1, OP_READ, 6'(a0)}, 9, rr);
    `CHK("dummy bit", 1'b0, rr[0])
    for (int i = 0; i < k; i++) begin
      host_u.shift(32'h0, 16, rr);
      `CHK("read word", exp_word(a0 + i), rr[15:0])
    end
    host_u.finish_cmd();
    `CHK("released", 1'b0, den)
  endtask

  // Main sequence
  initial begin
    err_total = 0;
    n_compared = 0;
    reset = 1'b1;
    s = $urandom(32'hA1F80A16);
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    repeat (2) @(posedge mclk);
    cmd(OP_EXT, 6'h30, 16'h0, 0, 0);
    d = 16'($urandom);
    cmd(OP_EXT, 6'h10, d, 1, 1);
    prog_wait();
    foreach (exp_mem[i]) exp_mem[i] = d;
    rd(0, WORDS);
    repeat (4) begin
      a = 6'($urandom);
      d = 16'($urandom);
      cmd(OP_WRITE, a, d, 1, 1'($urandom));
      prog_wait();
      exp_mem[a] = d;
      rd(a, 1);
    end
    // Deselect before the last data bit
    host_u.shift({7'h0, 1'b1, OP_WRITE, a, ~d} >> 1, 24, r);
    host_u.finish_cmd();
    rd(a, 1);
    cmd(OP_ERASE, 6'h3F, 16'h0, 0, 0);
    prog_wait();
    exp_mem[63] = ERASED_WORD;
    rd(62, 3);
    cmd(OP_EXT, 6'h00, 16'h0, 0, 0);
    cmd(OP_WRITE, a, ~exp_mem[a], 1, 0);
    host_u.poll(PROG + 5, s);
    `CHK("no status", 1'b0, den)
    host_u.finish_cmd();
    rd(a, 1);
    cmd(OP_EXT, 6'h30, 16'h0, 0, 0);
    cmd(OP_EXT, 6'h20, 16'h0, 0, 0);
    prog_wait();
    foreach (exp_mem[i]) exp_mem[i] = ERASED_WORD;
    rd(int'(6'($urandom)), 4);
    // Mid-run reset must drop write permission
    reset <= 1'b1;
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    repeat (2) @(posedge mclk);
    cmd(OP_WRITE, a, 16'h0000, 1, 0);
    repeat (PROG + 5) @(posedge mclk);
    rd(a, 1);
    conclude();
  end
endmodule // serial_eeprom_command_port_tb_top
